// ### verilog/crt_map.svh
// register indices, field positions and port addresses of the raster timing block
`ifndef CRT_MAP_SVH
`define CRT_MAP_SVH

// ------------------------------------------------------------
// i/o port addresses
// ------------------------------------------------------------
`define CRT_IO_INDEX_MONO      16'h03b4
`define CRT_IO_DATA_MONO       16'h03b5
`define CRT_IO_INDEX_COLOR     16'h03d4
`define CRT_IO_DATA_COLOR      16'h03d5

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define CRT_HORIZ_BLANK_START   5'h02
`define CRT_HORIZ_BLANK_END     5'h03
`define CRT_HORIZ_RETRACE_START 5'h04
`define CRT_HORIZ_RETRACE_END   5'h05
`define CRT_VERT_TOTAL_LOW      5'h06
`define CRT_VERTICAL_HIGH_BITS  5'h07
`define CRT_ROW_SCAN_PRESET     5'h08
`define CRT_ROW_HEIGHT          5'h09
`define CRT_CURSOR_FIRST_LINE   5'h0a
`define CRT_CURSOR_LAST_LINE    5'h0b
`define CRT_VERT_RETRACE_START  5'h10
`define CRT_VERT_RETRACE_END    5'h11
`define CRT_VERT_DISPLAY_END    5'h12
`define CRT_ROW_PITCH           5'h13
`define CRT_UNDERLINE_LINE      5'h14
`define CRT_VERT_BLANK_START    5'h15

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define CRT_HIGH_VT             0
`define CRT_HIGH_VDE            1
`define CRT_HIGH_VRS            2
`define CRT_HIGH_VBS            3
`define CRT_HIGH_LC             4
`define CRT_IRQ_CLEAR_N         4
`define CRT_IRQ_DISABLE         5
`define CRT_START_ODD           7
`define CRT_REG_RESET           8'h00

`endif

// ### verilog/crt_pkg.sv
// types shared by the raster timing block
package crt_pkg;

	// host i/o cycle, one strobe per access
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} crt_io_req_type;

	// timing values held outside this block
	typedef struct packed {
		logic [7:0]  horiz_total;
		logic [7:0]  horiz_display_end;
		logic [4:0]  vert_blank_end;
		logic        byte_mode;
		logic [15:0] frame_start_addr;
		logic [7:0]  cursor_column;
	} crt_ext_cfg_type;

	// whole state of the timing generator
	typedef struct packed {
		logic [7:0]       index;
		logic [31:0][7:0] regs;
		logic [7:0]       rdata;
		logic             rvalid;
		logic [7:0]       hcnt;
		logic [8:0]       vcnt;
		logic             horizontal_blank_signal;
		logic             hretr_raw;
		logic             hretr;
		logic             vretr;
		logic             vertical_blank_signal;
		logic             blank;
		logic [2:0]       de_pipe;
		logic             de;
		logic [2:0]       hr_pipe;
		logic [2:0]       cur_pipe;
		logic             cursor;
		logic             underline;
		logic [4:0]       row_scan;
		logic [15:0]      row_addr;
		logic [15:0]      addr_out;
		logic             irq;
	} crt_state_type;

endpackage : crt_pkg

// ### verilog/crt_timing.sv
// raster timing generator with indexed i/o register file
`timescale 1ns/10ps
`include "crt_map.svh"

// What this block does
// - horizontal blanking starts when character count equals blank start register.
// - horizontal blanking ends when counter low five bits match end field.
// - display enable is delayed zero to three character clocks by skew field.
// - horizontal retrace starts when character count equals retrace start register.
// - horizontal retrace ends when counter low five bits match end field.
// - horizontal retrace is delayed zero to three clocks by delay field.
// - row address after retrace starts even or odd per select bit.
// - vertical total is nine bits, ninth bit (bit eight) from high-bits register.
// - high-bits register supplies bit eight of total, retrace, blank, display end.
// - row scan counter loads preset value after each vertical retrace.
// - row scan counter increments per horizontal retrace, clears at maximum.
// - each character row is one line taller than row height value.
// - block cursor begins on scan line equal to first line value.
// - block cursor ends on scan line equal to end field minus one.
// - cursor is delayed zero to three characters by cursor skew field.
// - vertical retrace ends when scan counter low four bits match end.
// - writing zero to the clear bit drops the pending vertical interrupt.
// - vertical interrupt enabled when its enable bit is zero.
// - active display stops at nine-bit vertical display end line.
// - next row start is current start plus K times row pitch.
// - registers reached via index port then neighbouring data port.
// - word addressing when word/byte bit is zero, byte when one.
// - screen blank output is horizontal OR vertical blanking.
module crt_timing
	import crt_pkg::*;
(
	// clock and reset
	input  wire logic            core_clk_in,
	input  wire logic            srst_in,
	// host i/o port
	input  wire crt_io_req_type  io_req_in,
	input  wire logic            mono_sel_in,
	output logic [7:0]           io_rdata_out,
	output logic                 io_rvalid_out,
	// timing values from neighbouring blocks
	input  wire crt_ext_cfg_type ext_cfg_in,
	// monitor side
	output logic                 horizontal_blank_signal_out,
	output logic                 horizontal_retrace_out,
	output logic                 vertical_retrace_pulse_out,
	output logic                 vertical_blank_signal_out,
	output logic                 screen_blank_out,
	output logic                 display_enable_out,
	output logic                 vertical_interrupt_output_out,
	// address generator side
	output logic [4:0]           row_scan_out,
	output logic                 cursor_out,
	output logic                 underline_out,
	output logic [15:0]          row_start_addr_out
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// pick the current value or one of three older copies
	function automatic logic crt_skew(input logic now, input logic [2:0] pipe,
		input logic [1:0] sel);
		logic v;
		v = now;
		if (sel != 2'b00)
		begin
			v = pipe[sel - 2'b01];
		end
		return v;
	endfunction : crt_skew

	// indices that hold a register; the rest read as zero
	function automatic logic crt_impl(input logic [4:0] idx);
		logic hit;
		hit = 1'b0;
		case (idx)
			`CRT_HORIZ_BLANK_START,
			`CRT_HORIZ_BLANK_END,
			`CRT_HORIZ_RETRACE_START,
			`CRT_HORIZ_RETRACE_END,
			`CRT_VERT_TOTAL_LOW,
			`CRT_VERTICAL_HIGH_BITS,
			`CRT_ROW_SCAN_PRESET,
			`CRT_ROW_HEIGHT,
			`CRT_CURSOR_FIRST_LINE,
			`CRT_CURSOR_LAST_LINE,
			`CRT_VERT_RETRACE_START,
			`CRT_VERT_RETRACE_END,
			`CRT_VERT_DISPLAY_END,
			`CRT_ROW_PITCH,
			`CRT_UNDERLINE_LINE,
			`CRT_VERT_BLANK_START: hit = 1'b1;
			default:               hit = 1'b0;
		endcase
		return hit;
	endfunction : crt_impl

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	crt_state_type s;
	crt_state_type next_s;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [15:0] idx_port;
		logic [15:0] data_port;
		logic        data_wr;
		logic        line_end;
		logic        frame_end;
		logic [8:0]  vtotal;
		logic [8:0]  vrs;
		logic [8:0]  vbs;
		logic [8:0]  vde;
		logic        vdisp;
		logic        de_raw;
		logic        hr_start;
		logic        vr_start;
		logic        vr_end;
		logic        row_wrap;
		logic [15:0] pitch_step;
		logic [4:0]  cur_last;
		logic        cur_raw;
		logic [7:0]  r_hbe;
		logic [7:0]  r_hre;
		logic [7:0]  r_vre;
		logic [7:0]  r_high;
		logic [7:0]  r_cel;
		idx_port   = 16'h0000;
		data_port  = 16'h0000;
		data_wr    = 1'b0;
		line_end   = 1'b0;
		frame_end  = 1'b0;
		vtotal     = 9'h000;
		vrs        = 9'h000;
		vbs        = 9'h000;
		vde        = 9'h000;
		vdisp      = 1'b0;
		de_raw     = 1'b0;
		hr_start   = 1'b0;
		vr_start   = 1'b0;
		vr_end     = 1'b0;
		row_wrap   = 1'b0;
		pitch_step = 16'h0000;
		cur_last   = 5'h00;
		cur_raw    = 1'b0;
		next_s     = s;
		r_hbe      = s.regs[`CRT_HORIZ_BLANK_END];
		r_hre      = s.regs[`CRT_HORIZ_RETRACE_END];
		r_vre      = s.regs[`CRT_VERT_RETRACE_END];
		r_high     = s.regs[`CRT_VERTICAL_HIGH_BITS];
		r_cel      = s.regs[`CRT_CURSOR_LAST_LINE];

		// host port: index first, then data next to it
		idx_port  = mono_sel_in ? `CRT_IO_INDEX_MONO : `CRT_IO_INDEX_COLOR;
		data_port = mono_sel_in ? `CRT_IO_DATA_MONO : `CRT_IO_DATA_COLOR;
		next_s.rvalid = 1'b0;
		if (io_req_in.wr && io_req_in.addr == idx_port)
		begin
			next_s.index = io_req_in.wdata;
		end
		data_wr = io_req_in.wr && io_req_in.addr == data_port
			&& s.index[7:5] == 3'b000 && crt_impl(s.index[4:0]);
		if (data_wr)
		begin
			next_s.regs[s.index[4:0]] = io_req_in.wdata;
		end
		if (io_req_in.rd && io_req_in.addr == idx_port)
		begin
			// top bits of the index read back fixed, bit 5 is the AND of stored bits 7 and 6
			next_s.rdata  = {2'b11, &s.index[7:6], s.index[4:0]};
			next_s.rvalid = 1'b1;
		end
		else if (io_req_in.rd && io_req_in.addr == data_port)
		begin
			next_s.rdata = (s.index[7:5] == 3'b000 && crt_impl(s.index[4:0]))
				? s.regs[s.index[4:0]] : 8'h00;
			next_s.rvalid = 1'b1;
		end

		// nine-bit vertical values from low register plus high bits
		vtotal = {r_high[`CRT_HIGH_VT], s.regs[`CRT_VERT_TOTAL_LOW]};
		vrs    = {r_high[`CRT_HIGH_VRS], s.regs[`CRT_VERT_RETRACE_START]};
		vbs    = {r_high[`CRT_HIGH_VBS], s.regs[`CRT_VERT_BLANK_START]};
		vde    = {r_high[`CRT_HIGH_VDE], s.regs[`CRT_VERT_DISPLAY_END]};

		// character counter: line holds total plus two characters
		line_end = s.hcnt == ext_cfg_in.horiz_total + 8'h01;
		next_s.hcnt = line_end ? 8'h00 : s.hcnt + 8'h01;

		// horizontal blanking; a start on the end count wins
		if (s.hcnt[4:0] == r_hbe[4:0])
		begin
			next_s.horizontal_blank_signal = 1'b0;
		end
		if (s.hcnt == s.regs[`CRT_HORIZ_BLANK_START])
		begin
			next_s.horizontal_blank_signal = 1'b1;
		end

		// horizontal retrace before its delay stage
		hr_start = s.hcnt == s.regs[`CRT_HORIZ_RETRACE_START];
		if (s.hcnt[4:0] == r_hre[4:0])
		begin
			next_s.hretr_raw = 1'b0;
		end
		if (hr_start)
		begin
			next_s.hretr_raw = 1'b1;
		end
		next_s.hr_pipe = {s.hr_pipe[1:0], s.hretr_raw};
		next_s.hretr   = crt_skew(s.hretr_raw, s.hr_pipe, r_hre[6:5]);

		// scan line counter, one step per line
		frame_end = line_end && s.vcnt == vtotal;
		if (frame_end)
		begin
			next_s.vcnt = 9'h000;
		end
		else if (line_end)
		begin
			next_s.vcnt = s.vcnt + 9'h001;
		end

		// vertical retrace and blanking change only at line ends
		vr_start = line_end && s.vcnt == vrs && !s.vretr;
		vr_end   = line_end && s.vretr && s.vcnt[3:0] == r_vre[3:0];
		if (vr_end)
		begin
			next_s.vretr = 1'b0;
		end
		if (line_end && s.vcnt == vrs)
		begin
			next_s.vretr = 1'b1;
		end
		if (line_end && s.vcnt[4:0] == ext_cfg_in.vert_blank_end)
		begin
			next_s.vertical_blank_signal = 1'b0;
		end
		if (line_end && s.vcnt == vbs)
		begin
			next_s.vertical_blank_signal = 1'b1;
		end
		next_s.blank = next_s.horizontal_blank_signal | next_s.vertical_blank_signal;

		// vertical interrupt: a new retrace beats a clear in the same cycle
		if (data_wr && s.index[4:0] == `CRT_VERT_RETRACE_END
			&& !io_req_in.wdata[`CRT_IRQ_CLEAR_N])
		begin
			next_s.irq = 1'b0;
		end
		if (vr_start && !r_vre[`CRT_IRQ_DISABLE])
		begin
			next_s.irq = 1'b1;
		end

		// row scan counter; row is row height plus one lines tall
		row_wrap = s.row_scan == s.regs[`CRT_ROW_HEIGHT][4:0];
		if (vr_end)
		begin
			next_s.row_scan = s.regs[`CRT_ROW_SCAN_PRESET][4:0];
		end
		else if (hr_start)
		begin
			next_s.row_scan = row_wrap ? 5'h00 : s.row_scan + 5'h01;
		end

		// row start address: word mode steps by four, byte mode by two
		pitch_step = ext_cfg_in.byte_mode
			? {7'h00, s.regs[`CRT_ROW_PITCH], 1'b0}
			: {6'h00, s.regs[`CRT_ROW_PITCH], 2'b00};
		if (frame_end)
		begin
			next_s.row_addr = ext_cfg_in.frame_start_addr;
		end
		else if (hr_start && row_wrap && !vr_end)
		begin
			next_s.row_addr = s.row_addr + pitch_step;
		end
		// low bit forced so each line starts even or odd
		next_s.addr_out = {s.row_addr[15:1], r_hre[`CRT_START_ODD]};

		// display enable: both axes inside the active area
		vdisp  = s.vcnt <= vde;
		de_raw = vdisp && s.hcnt <= ext_cfg_in.horiz_display_end;
		next_s.de_pipe = {s.de_pipe[1:0], de_raw};
		next_s.de = crt_skew(de_raw, s.de_pipe, r_hbe[6:5]);

		// block cursor lines, then cursor column, then skew
		cur_last = r_cel[4:0] - 5'h01;
		cur_raw  = de_raw && s.hcnt == ext_cfg_in.cursor_column
			&& s.row_scan >= s.regs[`CRT_CURSOR_FIRST_LINE][4:0]
			&& s.row_scan <= cur_last;
		next_s.cur_pipe = {s.cur_pipe[1:0], cur_raw};
		next_s.cursor = crt_skew(cur_raw, s.cur_pipe, r_cel[6:5]);

		// register holds one less than the underline scan line
		next_s.underline = s.row_scan
			== s.regs[`CRT_UNDERLINE_LINE][4:0] + 5'h01;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// reset clears every register so the raster starts from the corner
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			s      <= '0;
			s.regs <= {32{`CRT_REG_RESET}};
		end
		else
		begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// outputs, all straight from the state register
	// ------------------------------------------------------------
	assign io_rdata_out                  = s.rdata;
	assign io_rvalid_out                 = s.rvalid;
	assign horizontal_blank_signal_out   = s.horizontal_blank_signal;
	assign horizontal_retrace_out        = s.hretr;
	assign vertical_retrace_pulse_out    = s.vretr;
	assign vertical_blank_signal_out     = s.vertical_blank_signal;
	assign screen_blank_out              = s.blank;
	assign display_enable_out            = s.de;
	assign vertical_interrupt_output_out = s.irq;
	assign row_scan_out                  = s.row_scan;
	assign cursor_out                    = s.cursor;
	assign underline_out                 = s.underline;
	assign row_start_addr_out            = s.addr_out;

endmodule : crt_timing

// ### test/crt_timing_props.sv
// port assertions for the raster timing block
`timescale 1ns/10ps
`include "crt_map.svh"
module crt_timing_props
	import crt_pkg::*;
(
	// clock and reset
	input wire logic            core_clk_in,
	input wire logic            srst_in,
	// host port
	input wire crt_io_req_type  io_req_in,
	input wire logic            mono_sel_in,
	input wire logic [7:0]      io_rdata_out,
	input wire logic            io_rvalid_out,
	input wire crt_ext_cfg_type ext_cfg_in,
	// raster outputs
	input wire logic            horizontal_blank_signal_out,
	input wire logic            vertical_retrace_pulse_out,
	input wire logic            vertical_blank_signal_out,
	input wire logic            screen_blank_out,
	input wire logic            vertical_interrupt_output_out,
	input wire logic [4:0]      row_scan_out,
	input wire logic            cursor_out,
	input wire logic [15:0]     row_start_addr_out
);
	logic [7:0]       idx, ex;
	logic [31:0][7:0] sh;
	logic [15:0]      stp;
	logic [3:0]       qt;
	logic             ip, dp, mp, rh, cw;
	// shadow of the host writes, so read data can be predicted
	assign ip = io_req_in.addr == (mono_sel_in ? `CRT_IO_INDEX_MONO : `CRT_IO_INDEX_COLOR);
	assign dp = io_req_in.addr == (mono_sel_in ? `CRT_IO_DATA_MONO : `CRT_IO_DATA_COLOR);
	assign mp = idx[7:5] == 3'h0 && ((idx[4:0] >= 5'h02 && idx[4:0] <= 5'h0b)
		|| (idx[4:0] >= 5'h10 && idx[4:0] <= 5'h15));
	assign ex = ip ? {2'b11, idx[7] & idx[6], idx[4:0]} : (mp ? sh[idx[4:0]] : 8'h00);
	assign rh = io_req_in.rd && (ip || dp);
	assign cw = io_req_in.wr && dp && idx == 8'h11 && !io_req_in.wdata[4];
	assign stp = (ext_cfg_in.byte_mode ? 16'h0002 : 16'h0004) * {8'h00, sh[5'h13]};
	// quiet counter: cursor pipe may still hold values from before a write
	always_ff @(posedge core_clk_in)
	begin
		if (srst_in)
		begin
			idx <= 8'h00;
			sh  <= '0;
			qt  <= 4'h0;
		end
		else
		begin
			if (io_req_in.wr && ip)
				idx <= io_req_in.wdata;
			if (io_req_in.wr && dp && mp)
				sh[idx[4:0]] <= io_req_in.wdata;
			qt <= (io_req_in.wr && dp) ? 4'h0 : (qt == 4'hf ? qt : qt + 4'h1);
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	property p_blank;
		screen_blank_out == (horizontal_blank_signal_out | vertical_blank_signal_out);
	endproperty
	a_blank: assert property (p_blank) else $error("screen blank not the or");
	property p_rvalid;
		1'b1 |=> io_rvalid_out == $past(rh);
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read answer timing");
	property p_rdata;
		rh |=> io_rdata_out == $past(ex);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data wrong");
	property p_irq_clr;
		cw && !vertical_retrace_pulse_out && $stable(vertical_retrace_pulse_out)
		|=> !vertical_interrupt_output_out || $rose(vertical_retrace_pulse_out);
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");
	property p_irq_off;
		sh[5'h11][5] && !vertical_interrupt_output_out |=> !vertical_interrupt_output_out;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked interrupt rose");
	property p_rowscan;
		$changed(row_scan_out) |-> row_scan_out == 5'h00 || row_scan_out == sh[8][4:0]
		|| row_scan_out == $past(row_scan_out) + 5'h01;
	endproperty
	a_rowscan: assert property (p_rowscan) else $error("row scan step");
	property p_addr;
		$changed(row_start_addr_out[15:1]) |->
		row_start_addr_out[15:1] == ext_cfg_in.frame_start_addr[15:1]
		|| row_start_addr_out[15:1] == ($past(row_start_addr_out) + $past(stp, 2)) >> 1;
	endproperty
	a_addr: assert property (p_addr) else $error("row start step");
	property p_cursor;
		cursor_out && qt > 4'h6 |-> row_scan_out >= sh[10][4:0]
		&& row_scan_out <= sh[11][4:0] - 5'h01;
	endproperty
	a_cursor: assert property (p_cursor) else $error("cursor line range");
	c_irq: cover property ($rose(vertical_interrupt_output_out));
	c_cur: cover property (cursor_out && qt > 4'h6);
	c_rd: cover property (rh);
endmodule : crt_timing_props

bind crt_timing crt_timing_props crt_timing_props_inst (
	.core_clk_in, .srst_in, .io_req_in, .mono_sel_in, .io_rdata_out, .io_rvalid_out,
	.ext_cfg_in, .horizontal_blank_signal_out, .vertical_retrace_pulse_out,
	.vertical_blank_signal_out, .screen_blank_out, .vertical_interrupt_output_out,
	.row_scan_out, .cursor_out, .row_start_addr_out
);

// ### test/crt_mon_model.sv
// monitor model: measures sync widths, offsets and frame length
`timescale 1ns/10ps
module crt_mon_model
(
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        srst_in,
	// raster signals as the monitor sees them
	input  wire logic        hb_in,
	input  wire logic        hr_in,
	input  wire logic        vr_in,
	input  wire logic        de_in,
	input  wire logic        cur_in,
	// measurements, see the bench for the slot meaning
	output logic [9:0][15:0] m_out
);
	logic [15:0] cyc, hb_r, hb_f, hr_r, ln, vl;
	logic [4:0]  p;
	// edge stamps on the character clock; widths are stamp differences
	always_ff @(posedge core_clk_in)
	begin
		p   <= {cur_in, de_in, vr_in, hr_in, hb_in};
		cyc <= cyc + 16'h0001;
		if (srst_in)
		begin
			{m_out, cyc, hb_r, hb_f, hr_r, ln, vl, p} <= '0;
		end
		else
		begin
			if (hb_in && !p[0])
			begin
				hb_r     <= cyc;
				m_out[4] <= cyc - hb_r;
				m_out[0] <= m_out[0] + 16'h0001;
			end
			if (!hb_in && p[0])
			begin
				hb_f     <= cyc;
				m_out[2] <= cyc - hb_r;
			end
			if (hr_in && !p[1])
			begin
				hr_r     <= cyc;
				m_out[5] <= cyc - hb_r;
				ln       <= ln + 16'h0001;
				vl       <= vl + {15'h0000, vr_in};
			end
			if (!hr_in && p[1])
				m_out[3] <= cyc - hr_r;
			// lines are counted in retrace pulses, as a monitor does
			if (vr_in && !p[2])
			begin
				m_out[7] <= ln;
				ln       <= '0;
				vl       <= '0;
				m_out[1] <= m_out[1] + 16'h0001;
			end
			if (!vr_in && p[2])
				m_out[8] <= vl;
			if (!de_in && p[3])
				m_out[6] <= cyc - hb_f;
			if (cur_in && !p[4])
				m_out[9] <= m_out[9] + 16'h0001;
		end
	end
endmodule : crt_mon_model

// ### test/tb_crt_timing.sv
// self-checking bench of the raster timing block
`timescale 1ns/10ps
`include "crt_map.svh"
module tb_crt_timing
	import crt_pkg::*;
;
	// stimulus and observed signals
	logic             core_clk_in = 1'b0;
	logic             srst_in     = 1'b1;
	logic             mono_sel_in = 1'b0;
	crt_io_req_type   io_req_in   = '0;
	crt_ext_cfg_type  ext_cfg_in  = '{8'h0e, 8'h02, 5'h02, 1'b0, 16'h0100, 8'h01};
	logic [7:0]       io_rdata_out;
	logic             io_rvalid_out, hb, hr, vr, vb, sb, de, irq, cur, ul;
	logic [4:0]       row_scan_out;
	logic [15:0]      row_start_addr_out, ipa;
	logic [9:0][15:0] m;
	logic [7:0]       ti [16] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
		8'h0a, 8'h0b, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
	logic [7:0]       tv [16] = '{8'h04, 8'h09, 8'h06, 8'h0a, 8'h14, 8'h00, 8'h00, 8'h02,
		8'h01, 8'h22, 8'h03, 8'h06, 8'h0c, 8'h03, 8'h00, 8'h12};
	int               errors = 0;
	int               cmp_count = 0;
	int               i;

	always #20 core_clk_in = ~core_clk_in;

	crt_timing crt_timing_inst (.core_clk_in, .srst_in, .io_req_in, .mono_sel_in,
		.io_rdata_out, .io_rvalid_out, .ext_cfg_in, .horizontal_blank_signal_out(hb),
		.horizontal_retrace_out(hr), .vertical_retrace_pulse_out(vr),
		.vertical_blank_signal_out(vb), .screen_blank_out(sb), .display_enable_out(de),
		.vertical_interrupt_output_out(irq), .row_scan_out, .cursor_out(cur),
		.underline_out(ul), .row_start_addr_out);
	crt_mon_model crt_mon_model_inst (.core_clk_in, .srst_in, .hb_in(hb), .hr_in(hr),
		.vr_in(vr), .de_in(de), .cur_in(cur), .m_out(m));

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// inputs move 1 ns after the edge, never on it
	task automatic step;
		@(posedge core_clk_in);
		#1;
	endtask : step
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one strobe cycle, then a quiet edge before the next
	task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
		step;
		io_req_in = '{a, w, !w, d};
		step;
		io_req_in = '0;
	endtask : io
	task automatic wr(input logic [7:0] x, input logic [7:0] v);
		io(1'b1, ipa, x);
		io(1'b1, ipa + 16'h0001, v);
	endtask : wr
	task automatic rd(input logic [7:0] x, input logic [7:0] e);
		io(1'b1, ipa, x);
		io(1'b0, ipa + 16'h0001, 8'h00);
		check({15'h0000, io_rvalid_out}, 16'h0001);
		check({8'h00, io_rdata_out}, {8'h00, e});
	endtask : rd
	// waits for n more events in a model slot: 0 lines, 1 frames
	task automatic wait_ev(input int w, input int n);
		logic [15:0] s;
		int k;
		s = m[w];
		for (k = 0; k < 20000 && m[w] !== s + n; k++)
			step;
		if (k == 20000)
		begin
			errors++;
			$display("timeout at %0t", $time);
			results;
		end
	endtask : wait_ev

	task automatic t_regs;
		for (i = 0; i < 16; i++)
			wr(ti[i], tv[i]);
		for (i = 0; i < 16; i++)
			rd(ti[i], tv[i]);
		rd(8'h0c, 8'h00);
		io(1'b1, ipa, 8'he5);
		io(1'b0, ipa, 8'h00);
		check({8'h00, io_rdata_out}, 16'h00e5);
		mono_sel_in = 1'b1;
		ipa = `CRT_IO_INDEX_MONO;
		io(1'b1, ipa, 8'h02);
		io(1'b1, `CRT_IO_DATA_COLOR, 8'hff);
		rd(8'h02, 8'h04);
		mono_sel_in = 1'b0;
		ipa = `CRT_IO_INDEX_COLOR;
		$display("test registers done");
	endtask : t_regs
	task automatic t_horiz;
		for (i = 0; i < 4; i++)
		begin
			wr(8'h03, {1'b0, i[1:0], 5'h09});
			wr(8'h05, {1'b0, i[1:0], 5'h0a});
			// enough lines that a displayed line follows the vertical border
			wait_ev(0, 12);
			check(m[2], 16'h0005);
			check(m[3], 16'h0004);
			check(m[4], 16'h0010);
			check(m[5], 16'h0003 + i[15:0]);
			check(m[6], 16'h000a + i[15:0]);
		end
		wr(8'h05, 8'h8a);
		wait_ev(0, 2);
		check({15'h0000, row_start_addr_out[0]}, 16'h0001);
		wr(8'h05, 8'h0a);
		wait_ev(0, 2);
		check({15'h0000, row_start_addr_out[0]}, 16'h0000);
		$display("test horizontal done");
	endtask : t_horiz
	task automatic t_vert;
		wait_ev(1, 2);
		check(m[7], 16'h0015);
		check(m[8], 16'h0003);
		check({15'h0000, m[9] != 16'h0000}, 16'h0001);
		wr(8'h06, 8'h00);
		wr(8'h07, 8'h01);
		ext_cfg_in.byte_mode = 1'b1;
		wait_ev(1, 2);
		check(m[7], 16'h0101);
		wr(8'h06, 8'h14);
		wr(8'h07, 8'h00);
		$display("test vertical done");
	endtask : t_vert
	task automatic t_irq;
		wr(8'h11, 8'h06);
		for (i = 0; i < 20000 && irq !== 1'b1; i++)
			step;
		check({15'h0000, irq}, 16'h0001);
		if (i == 20000)
			results;
		wr(8'h11, 8'h16);
		check({15'h0000, irq}, 16'h0001);
		wr(8'h11, 8'h06);
		check({15'h0000, irq}, 16'h0000);
		wr(8'h11, 8'h26);
		wait_ev(1, 2);
		check({15'h0000, irq}, 16'h0000);
		$display("test interrupt done");
	endtask : t_irq
	// underline flag follows the scan line one clock late
	task automatic t_under;
		logic [4:0] prev;
		int k;
		prev = row_scan_out;
		for (k = 0; k < 100 && ul !== 1'b0; k++)
			step;
		for (k = 0; k < 2000 && ul !== 1'b1; k++)
		begin
			prev = row_scan_out;
			step;
		end
		check({11'h000, prev}, 16'h0001);
		$display("test underline done");
	endtask : t_under

	// main sequence: reset for 16 clocks, then the scenarios
	initial
	begin
		ipa = `CRT_IO_INDEX_COLOR;
		repeat (16) @(posedge core_clk_in);
		#1;
		srst_in = 1'b0;
		t_regs;
		t_horiz;
		t_vert;
		t_irq;
		t_under;
		results;
	end
endmodule : tb_crt_timing
